// file: src/naf_pkg.sv
// Shared constants and types for the NAND phase formatter
package naf_pkg;
  localparam int CHIP_HI = 31;
  localparam int CHIP_LO = 24;
  localparam int CYC_HI = 23;
  localparam int CYC_LO = 21;
  localparam int CLR_CS_BIT = 21;
  localparam int END_VALID_BIT = 20;
  localparam int PHASE_BIT = 19;
  localparam int END_HI = 18;
  localparam int END_LO = 11;
  localparam int START_HI = 10;
  localparam int START_LO = 3;
  localparam int ECC_LAST_BIT = 10;
  localparam int LANE_HI = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [2:0] LANE_LAST = 3'h7;
  // Low time of a NAND strobe (one tick) and the clock it is counted in
  localparam int CLK_NS = 20;
  localparam int STROBE_NS = 40;
  localparam int TICK_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_END, ST_DRAIN, ST_WDATA, ST_RESP, ST_RDATA, ST_RBEAT
  } naf_state_t;
endpackage

// file: src/naf_fifo.sv
// Write data FIFO with registered output stage
`timescale 1ns/10ps
module naf_fifo #(
  parameter int WIDTH = 73,
  parameter int DEPTH = 16
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  wire push = i_valid & o_ready;
  wire load = (cnt_r != '0) & (~o_valid | i_ready);
  assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

  always_ff @(posedge i_mclk)
  begin
    if (push)
      mem[wp_r] <= i_data;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      o_ready <= 1'b0;
      o_valid <= 1'b0;
      o_data <= '0;
    end
    else
    begin
      wp_r <= push ? wp_r + 1'b1 : wp_r;
      rp_r <= load ? rp_r + 1'b1 : rp_r;
      cnt_r <= cnt_nxt;
      // Ready is registered, so it looks one word ahead of the count
      o_ready <= (cnt_nxt < (AW + 1)'(DEPTH - 1)) | ((cnt_nxt == (AW + 1)'(DEPTH - 1)) & ~push);
      if (load)
      begin
        o_data <= mem[rp_r];
        o_valid <= 1'b1;
      end
      else if (i_ready)
        o_valid <= 1'b0;
    end
  end
endmodule

// file: src/naf_formatter.sv
// AXI to NAND command and data phase formatter
`timescale 1ns/10ps
module naf_formatter #(
  parameter int NCS = 2,
  parameter int DEPTH = naf_pkg::FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [NCS*8-1:0] i_chip_mask,
  input wire logic [NCS*8-1:0] i_chip_match,
  input wire logic i_cs_hold,
  input wire logic i_ecc_en,
  input wire logic i_rdy_clr,
  input wire logic i_aw_valid,
  input wire logic [31:0] i_aw_addr,
  output logic o_aw_ready,
  input wire logic i_w_valid,
  input wire logic [63:0] i_w_data,
  input wire logic [7:0] i_w_strb,
  input wire logic i_w_last,
  output logic o_w_ready,
  output logic o_b_valid,
  output logic [1:0] o_b_resp,
  input wire logic i_b_ready,
  input wire logic i_ar_valid,
  input wire logic [31:0] i_ar_addr,
  input wire logic [7:0] i_ar_len,
  input wire logic [2:0] i_ar_size,
  output logic o_ar_ready,
  output logic o_r_valid,
  output logic [63:0] o_r_data,
  output logic [1:0] o_r_resp,
  output logic o_r_last,
  input wire logic i_r_ready,
  output logic [NCS-1:0] o_cs_n,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_re_n,
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_dq_oe,
  input wire logic i_rb,
  output logic o_rdy_flag,
  output logic o_ecc_last
);
  function automatic logic [NCS-1:0] chip_hit(input logic [7:0] top,
      input logic [NCS*8-1:0] msk, input logic [NCS*8-1:0] mat);
    logic [NCS-1:0] h;
    h = '0;
    for (int i = 0; i < NCS; i++)
      h[i] = (top & msk[i*8 +: 8]) == mat[i*8 +: 8];
    return h;
  endfunction

  function automatic logic [3:0] size_bytes(input logic [2:0] sz);
    return (sz > 3'h3) ? 4'h8 : 4'(4'h1 << sz);
  endfunction

  naf_pkg::naf_state_t state_r;
  logic [31:0] addr_r;
  logic [2:0] cyc_left_r;
  logic [2:0] lane_r;
  logic [7:0] beats_left_r;
  logic [3:0] bytes_left_r;
  logic [2:0] size_r;
  logic [1:0] tcnt_r;
  logic ce_act_r;
  logic ce_ph_r;
  logic [7:0] dq_s1_r;
  logic [7:0] dq_s2_r;
  logic rb_s1_r;
  logic rb_s2_r;
  logic rb_d_r;

  // FIFO word: last flag, strobes, data
  logic f_v;
  logic [72:0] f_word;
  logic f_pop;
  wire [63:0] f_data = f_word[63:0];
  wire [7:0] f_strb = f_word[71:64];
  wire f_last = f_word[72];

  naf_fifo #(.WIDTH(73), .DEPTH(DEPTH)) u_wfifo (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_valid(i_w_valid),
    .i_data({i_w_last, i_w_strb, i_w_data}),
    .o_ready(o_w_ready),
    .o_valid(f_v),
    .o_data(f_word),
    .i_ready(f_pop)
  );

  wire aw_take = i_aw_valid & o_aw_ready;
  wire ar_take = i_ar_valid & o_ar_ready;
  wire is_data = addr_r[naf_pkg::PHASE_BIT];
  wire end_ok = addr_r[naf_pkg::END_VALID_BIT];
  wire [7:0] start_op = addr_r[naf_pkg::START_HI:naf_pkg::START_LO];
  wire [7:0] end_op = addr_r[naf_pkg::END_HI:naf_pkg::END_LO];
  wire [7:0] lane_byte = f_data[{lane_r, 3'h0} +: 8];
  wire tick = (tcnt_r == 2'h0);
  wire ce_done = ce_act_r & ce_ph_r & tick;
  wire last_lane = (lane_r == naf_pkg::LANE_LAST);
  wire wd_adv = (state_r == naf_pkg::ST_WDATA) & f_v & (~f_strb[lane_r] | ce_done);
  wire ad_adv = (state_r == naf_pkg::ST_ADDR) & ce_done;
  wire drain_pop = (state_r == naf_pkg::ST_DRAIN) & f_v;
  wire finish = ((state_r == naf_pkg::ST_RESP) & i_b_ready)
              | ((state_r == naf_pkg::ST_RBEAT) & i_r_ready & o_r_last);
  // Data phases end by bit 21; command phases by the hold tie-off
  wire cs_release = is_data ? addr_r[naf_pkg::CLR_CS_BIT] : ~i_cs_hold;
  wire rb_rise = rb_s2_r & ~rb_d_r;

  // address byte use
  // The word holding the final address byte is left for the drain, which sees its last flag
  assign f_pop = drain_pop | (ad_adv & last_lane & (cyc_left_r != 3'h1))
               | (wd_adv & last_lane);

  // Strobe request and what it puts on the pins
  wire ce_req = (state_r == naf_pkg::ST_CMD) | (state_r == naf_pkg::ST_END)
              | ((state_r == naf_pkg::ST_ADDR) & f_v)
              | ((state_r == naf_pkg::ST_WDATA) & f_v & f_strb[lane_r])
              | (state_r == naf_pkg::ST_RDATA);
  wire ce_start = ce_req & ~ce_act_r & tick;
  wire req_cle = (state_r == naf_pkg::ST_CMD) | (state_r == naf_pkg::ST_END);
  wire req_ale = (state_r == naf_pkg::ST_ADDR);
  wire req_rd = (state_r == naf_pkg::ST_RDATA);
  wire [7:0] req_byte = (state_r == naf_pkg::ST_CMD) ? start_op
                      : (state_r == naf_pkg::ST_END) ? end_op : lane_byte;

  // Pins from outside pass two flops before use
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
      // Wired ready line idles high, so no false rise follows reset
      rb_s1_r <= 1'b1;
      rb_s2_r <= 1'b1;
      rb_d_r <= 1'b1;
      o_rdy_flag <= 1'b0;
    end
    else
    begin
      dq_s1_r <= i_dq;
      dq_s2_r <= dq_s1_r;
      rb_s1_r <= i_rb;
      rb_s2_r <= rb_s1_r;
      rb_d_r <= rb_s2_r;
      // sticky ready flag, a new rise beats the clear
      o_rdy_flag <= rb_rise | (o_rdy_flag & ~i_rdy_clr);
    end
  end

  // Strobe engine: one tick low, then two ticks high before the next byte starts
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tcnt_r <= 2'h0;
      ce_act_r <= 1'b0;
      ce_ph_r <= 1'b0;
      o_cle <= 1'b0;
      o_ale <= 1'b0;
      o_we_n <= 1'b1;
      o_re_n <= 1'b1;
      o_dq <= 8'h00;
      o_dq_oe <= 1'b0;
    end
    else
    begin
      tcnt_r <= tick ? 2'(naf_pkg::TICK_CYC - 1) : tcnt_r - 2'h1;
      if (ce_start)
      begin
        ce_act_r <= 1'b1;
        ce_ph_r <= 1'b0;
        o_cle <= req_cle;
        o_ale <= req_ale;
        o_we_n <= req_rd;
        o_re_n <= ~req_rd;
        o_dq <= req_byte;
        o_dq_oe <= ~req_rd;
      end
      else if (ce_act_r & tick & ~ce_ph_r)
      begin
        ce_ph_r <= 1'b1;
        o_we_n <= 1'b1;
        o_re_n <= 1'b1;
      end
      else if (ce_done)
      begin
        ce_act_r <= 1'b0;
        o_cle <= 1'b0;
        o_ale <= 1'b0;
        o_dq_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_r <= naf_pkg::ST_IDLE;
      addr_r <= 32'h0000_0000;
      cyc_left_r <= 3'h0;
      lane_r <= 3'h0;
      beats_left_r <= 8'h00;
      bytes_left_r <= 4'h0;
      size_r <= 3'h0;
      o_aw_ready <= 1'b1;
      o_ar_ready <= 1'b0;
      o_b_valid <= 1'b0;
      o_b_resp <= naf_pkg::RESP_OKAY;
      o_r_valid <= 1'b0;
      o_r_data <= 64'h0;
      o_r_resp <= naf_pkg::RESP_OKAY;
      o_r_last <= 1'b0;
      o_cs_n <= '1;
      o_ecc_last <= 1'b0;
    end
    else
    begin
      o_ecc_last <= 1'b0;
      unique case (state_r)
        naf_pkg::ST_IDLE:
        begin
          // Offer the two channels in turn, writes first after each finish, so steady writes starve reads
          o_aw_ready <= o_ar_ready & ~ar_take;
          o_ar_ready <= o_aw_ready & ~aw_take;
          lane_r <= aw_take ? i_aw_addr[naf_pkg::LANE_HI:0] : i_ar_addr[naf_pkg::LANE_HI:0];
          if (aw_take)
          begin
            addr_r <= i_aw_addr;
            // write side select; no hit leaves all off
            o_cs_n <= ~chip_hit(i_aw_addr[naf_pkg::CHIP_HI:naf_pkg::CHIP_LO],
                i_chip_mask, i_chip_match);
            // address cycle count, command phases only
            cyc_left_r <= i_aw_addr[naf_pkg::PHASE_BIT] ? 3'h0
                        : i_aw_addr[naf_pkg::CYC_HI:naf_pkg::CYC_LO];
            state_r <= i_aw_addr[naf_pkg::PHASE_BIT] ? naf_pkg::ST_WDATA : naf_pkg::ST_CMD;
          end
          else if (ar_take)
          begin
            addr_r <= i_ar_addr;
            o_cs_n <= ~chip_hit(i_ar_addr[naf_pkg::CHIP_HI:naf_pkg::CHIP_LO],
                i_chip_mask, i_chip_match);
            beats_left_r <= i_ar_len;
            size_r <= i_ar_size;
            bytes_left_r <= size_bytes(i_ar_size);
            o_r_data <= 64'h0;
            // read data phase; reads never start a command phase
            state_r <= naf_pkg::ST_RDATA;
          end
        end
        naf_pkg::ST_CMD:
        begin
          // closing opcode only after the address cycles
          if (ce_done)
            state_r <= (cyc_left_r != 3'h0) ? naf_pkg::ST_ADDR
                     : end_ok ? naf_pkg::ST_END : naf_pkg::ST_DRAIN;
        end
        naf_pkg::ST_ADDR:
        begin
          if (ad_adv)
          begin
            lane_r <= lane_r + 3'h1;
            cyc_left_r <= cyc_left_r - 3'h1;
            if (cyc_left_r == 3'h1)
              state_r <= end_ok ? naf_pkg::ST_END : naf_pkg::ST_DRAIN;
          end
        end
        naf_pkg::ST_END:
        begin
          if (ce_done)
            state_r <= is_data ? naf_pkg::ST_RESP : naf_pkg::ST_DRAIN;
        end
        naf_pkg::ST_DRAIN:
        begin
          // Leftover beats of a split address write are dropped
          if (drain_pop & f_last)
            state_r <= naf_pkg::ST_RESP;
        end
        naf_pkg::ST_WDATA:
        begin
          // unstrobed lanes skipped, first lane from bits 2:0
          if (wd_adv)
          begin
            lane_r <= lane_r + 3'h1;
            // closing opcode after the written data
            if (last_lane & f_last)
              state_r <= end_ok ? naf_pkg::ST_END : naf_pkg::ST_RESP;
          end
        end
        naf_pkg::ST_RESP:
        begin
          o_b_valid <= ~i_b_ready;
          o_b_resp <= naf_pkg::RESP_OKAY;
        end
        naf_pkg::ST_RDATA:
        begin
          if (ce_done)
          begin
            o_r_data[{lane_r, 3'h0} +: 8] <= dq_s2_r;
            lane_r <= lane_r + 3'h1;
            bytes_left_r <= bytes_left_r - 4'h1;
            if (bytes_left_r == 4'h1)
            begin
              o_r_valid <= 1'b1;
              o_r_last <= (beats_left_r == 8'h00);
              o_r_resp <= naf_pkg::RESP_OKAY;
              state_r <= naf_pkg::ST_RBEAT;
            end
          end
        end
        naf_pkg::ST_RBEAT:
        begin
          if (i_r_ready)
          begin
            o_r_valid <= 1'b0;
            o_r_last <= 1'b0;
            if (!o_r_last)
            begin
              beats_left_r <= beats_left_r - 8'h01;
              bytes_left_r <= size_bytes(size_r);
              o_r_data <= 64'h0;
              state_r <= naf_pkg::ST_RDATA;
            end
          end
        end
      endcase
      if ((state_r != naf_pkg::ST_RESP) && (state_r != naf_pkg::ST_IDLE))
        o_b_valid <= (state_r == naf_pkg::ST_DRAIN) ? drain_pop & f_last
                   : ((state_r == naf_pkg::ST_WDATA) & wd_adv & last_lane & f_last & ~end_ok)
                   | ((state_r == naf_pkg::ST_END) & ce_done & is_data);
      if (finish)
      begin
        state_r <= naf_pkg::ST_IDLE;
        o_aw_ready <= 1'b1;
        o_ar_ready <= 1'b0;
        // release on bit 21; hold across command to data
        if (cs_release)
          o_cs_n <= '1;
        // page last marker, gated by ECC enable
        o_ecc_last <= is_data & addr_r[naf_pkg::ECC_LAST_BIT] & i_ecc_en;
      end
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  chk_phase_decode: assert property (aw_take |=>
      state_r == ($past(i_aw_addr[naf_pkg::PHASE_BIT]) ? naf_pkg::ST_WDATA : naf_pkg::ST_CMD))
    else $error("phase decode wrong");
  chk_chip_select: assert property (ar_take |=> o_cs_n ==
      ~chip_hit($past(i_ar_addr[31:24]), $past(i_chip_mask), $past(i_chip_match)))
    else $error("chip select does not match address");
  chk_cycle_count: assert property ((aw_take & ~i_aw_addr[19]) |=>
      cyc_left_r == $past(i_aw_addr[23:21]))
    else $error("address cycle count not loaded");
  chk_start_opcode: assert property ((state_r == naf_pkg::ST_CMD && ce_act_r) |->
      o_cle && !o_ale && o_dq == start_op)
    else $error("start opcode not on pins");
  chk_end_after_addr: assert property ((state_r == naf_pkg::ST_END) |->
      end_ok && cyc_left_r == 3'h0)
    else $error("closing opcode out of place");
  chk_addr_byte_use: assert property ((ad_adv && last_lane && cyc_left_r != 3'h1) |-> f_pop)
    else $error("address word not consumed");
  chk_cs_release: assert property ((finish && is_data && addr_r[21]) |=>
      o_cs_n == '1)
    else $error("chip select not released");
  chk_cs_hold: assert property ((finish && !is_data && i_cs_hold) |=>
      $stable(o_cs_n))
    else $error("chip select dropped despite hold");
  chk_ecc_last: assert property (o_ecc_last |-> $past(finish) &&
      $past(addr_r[10]) && $past(i_ecc_en))
    else $error("ecc last without cause");
  chk_ready_flag: assert property (rb_rise |=> o_rdy_flag)
    else $error("ready rise not flagged");
endmodule

// file: verif/naf_flash_model.sv
// Behavioural NAND flash pair on the formatter's memory pins
`timescale 1ns/10ps
module naf_flash_model #(
  parameter logic [7:0] BUSY_OP = 8'h10,
  parameter int BUSY_NS = 400
) (
  input wire logic [1:0] i_cs_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_re_n,
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_rb
);
  logic [9:0] log_q[$];
  logic [7:0] pat = 8'h5A;
  wire sel = (i_cs_n != 2'h3);
  initial o_dq = 8'h00;
  initial o_rb = 1'b1;
  // Deselected dies ignore strobes, so unmatched cycles leave no trace
  always @(posedge i_we_n)
    if (sel)
      log_q.push_back({i_cle, i_ale, i_dq});
  always @(negedge i_re_n)
    if (sel)
    begin
      o_dq = pat;
      pat = pat + 8'h01;
    end
  // Data turns to junk once the hold time after the strobe has run out
  always @(posedge i_re_n)
  begin
    #30;
    o_dq = ~o_dq;
  end
  always @(posedge i_we_n)
    if (sel && i_cle && i_dq == BUSY_OP)
    begin
      o_rb = 1'b0;
      #(BUSY_NS);
      o_rb = 1'b1;
    end
endmodule

// file: verif/testbench.sv
// Self-checking bench for the NAND phase formatter
`timescale 1ns/10ps
module testbench;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_cs_hold = 1'b0;
  logic i_ecc_en = 1'b1;
  logic i_rdy_clr = 1'b0;
  logic i_aw_valid = 1'b0;
  logic i_w_valid = 1'b0;
  logic i_ar_valid = 1'b0;
  logic i_b_ready = 1'b1;
  logic i_r_ready = 1'b1;
  logic [31:0] i_aw_addr = 32'h0;
  logic [31:0] i_ar_addr = 32'h0;
  logic [7:0] i_ar_len = 8'h00;
  logic [2:0] i_ar_size = 3'h0;
  logic [63:0] i_w_data = 64'h0;
  logic [7:0] i_w_strb = 8'h0;
  logic o_aw_ready, o_w_ready, o_b_valid, o_ar_ready, o_r_valid, o_r_last;
  logic o_cle, o_ale, o_we_n, o_re_n, o_dq_oe, o_rdy_flag, o_ecc_last, rb;
  logic [1:0] o_b_resp, o_r_resp, o_cs_n, bresp, rresp;
  logic [63:0] o_r_data, rdata;
  logic [7:0] o_dq, mdl_dq;
  wire [7:0] dq_bus = o_dq_oe ? o_dq : mdl_dq;
  int errors = 0;
  int check_count = 0;
  int ecc_cnt = 0;
  logic rlast;
  logic [1:0] cs_seen = 2'h0;
  logic [9:0] exp_q[$];
  always #10 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
  begin
    cs_seen <= cs_seen | ~o_cs_n;
    if (o_ecc_last === 1'b1)
      ecc_cnt <= ecc_cnt + 1;
  end
  naf_formatter DUT (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_chip_mask(16'hF0F0),
    .i_chip_match(16'h2010), .i_cs_hold(i_cs_hold), .i_ecc_en(i_ecc_en),
    .i_rdy_clr(i_rdy_clr), .i_aw_valid(i_aw_valid), .i_aw_addr(i_aw_addr),
    .o_aw_ready(o_aw_ready), .i_w_valid(i_w_valid), .i_w_data(i_w_data), .i_w_strb(i_w_strb),
    .i_w_last(1'b1), .o_w_ready(o_w_ready), .o_b_valid(o_b_valid), .o_b_resp(o_b_resp),
    .i_b_ready(i_b_ready), .i_ar_valid(i_ar_valid), .i_ar_addr(i_ar_addr),
    .i_ar_len(i_ar_len), .i_ar_size(i_ar_size), .o_ar_ready(o_ar_ready),
    .o_r_valid(o_r_valid), .o_r_data(o_r_data),
    .o_r_resp(o_r_resp), .o_r_last(o_r_last), .i_r_ready(i_r_ready), .o_cs_n(o_cs_n),
    .o_cle(o_cle), .o_ale(o_ale), .o_we_n(o_we_n), .o_re_n(o_re_n), .i_dq(dq_bus),
    .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_rb(rb), .o_rdy_flag(o_rdy_flag),
    .o_ecc_last(o_ecc_last));
  naf_flash_model flash (.i_cs_n(o_cs_n), .i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n),
    .i_re_n(o_re_n), .i_dq(dq_bus), .o_dq(mdl_dq), .o_rb(rb));
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic timeout(input string name);
    chk(name, 64'h0, 64'h1);
    close_out();
  endtask
  function automatic logic [31:0] na(input logic [7:0] top, input logic [2:0] cyc,
      input logic endv, input logic dph, input logic [7:0] endop, input logic [7:0] start,
      input logic [2:0] low);
    return {top, cyc, endv, dph, endop, start, low};
  endfunction
  task automatic push_bytes(input logic [1:0] kind, input logic [63:0] d, input int n);
    for (int k = 0; k < n; k++)
      exp_q.push_back({kind, d[k*8 +: 8]});
  endtask
  task automatic chk_log();
    chk("log size", 64'(flash.log_q.size()), 64'(exp_q.size()));
    foreach (exp_q[i])
      if (i < flash.log_q.size())
        chk("nand byte", 64'(flash.log_q[i]), 64'(exp_q[i]));
    flash.log_q.delete();
    exp_q.delete();
  endtask
  // Finish lands on the handshake edge and ecc_cnt counts its pulse one edge later, so settle two edges
  task automatic settle();
    repeat (2) @(posedge i_mclk);
    #1;
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [63:0] d, input logic [7:0] s);
    logic aw_done;
    logic w_done;
    logic b_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    b_done = 1'b0;
    cs_seen = 2'h0;
    i_aw_addr = a;
    i_w_data = d;
    i_w_strb = s;
    i_aw_valid = 1'b1;
    i_w_valid = 1'b1;
    for (int n = 0; n < 3000 && !b_done; n++)
    begin
      @(posedge i_mclk);
      aw_done |= i_aw_valid & (o_aw_ready === 1'b1);
      w_done |= i_w_valid & (o_w_ready === 1'b1);
      b_done = (o_b_valid === 1'b1);
      bresp = o_b_resp;
      #1;
      i_aw_valid = ~aw_done;
      i_w_valid = ~w_done;
    end
    if (!b_done)
      timeout("write response");
    else
      settle();
  endtask
  task automatic axi_rd(input logic [31:0] a);
    logic ar_done;
    logic r_done;
    ar_done = 1'b0;
    r_done = 1'b0;
    i_ar_addr = a;
    i_ar_valid = 1'b1;
    for (int n = 0; n < 3000 && !r_done; n++)
    begin
      @(posedge i_mclk);
      ar_done |= i_ar_valid & (o_ar_ready === 1'b1);
      r_done = (o_r_valid === 1'b1);
      rdata = o_r_data;
      rlast = o_r_last;
      rresp = o_r_resp;
      #1;
      i_ar_valid = ~ar_done;
    end
    if (!r_done)
      timeout("read data");
    else
      settle();
  endtask
  task automatic t_reset();
    chk("cs_n in reset", o_cs_n, 2'h3);
    chk("pins in reset", {o_we_n, o_re_n, o_cle, o_ale, o_dq_oe}, 5'h18);
  endtask
  task automatic t_cmd(input logic hold, input logic [2:0] cyc, input logic endv);
    i_cs_hold = hold;
    axi_wr(na(8'h10, cyc, endv, 1'b0, 8'h30, 8'h90, 3'h0), 64'h0077_6655_4433_2211, 8'hFF);
    exp_q.push_back({2'b10, 8'h90});
    push_bytes(2'b01, 64'h0077_6655_4433_2211, int'(cyc));
    if (endv)
      exp_q.push_back({2'b10, 8'h30});
    chk_log();
    chk("chip 0 used", cs_seen, 2'h1);
    chk("cs after command", o_cs_n, {1'b1, ~hold});
  endtask
  // full doubleword beats, wider than the flash bus
  task automatic t_wkeep();
    axi_wr(na(8'h10, 3'h0, 1'b0, 1'b1, 8'h00, 8'h00, 3'h0), 64'h8877_6655_4433_2211, 8'hFF);
    push_bytes(2'b00, 64'h8877_6655_4433_2211, 8);
    chk_log();
    chk("cs held", o_cs_n, 2'h2);
    i_cs_hold = 1'b0;
  endtask
  task automatic t_read();
    for (int e = 0; e < 2; e++)
    begin
      i_ecc_en = (e == 0);
      axi_rd(na(8'h10, 3'h1, 1'b0, 1'b1, 8'h00, 8'h80, 3'h3));
      chk("read data", rdata, {32'h0, 8'(8'h5A + e), 24'h0});
      chk("read last", {rlast, rresp}, {1'b1, naf_pkg::RESP_OKAY});
      chk("ecc last count", 64'(ecc_cnt), 64'h1);
      chk("cs released", o_cs_n, 2'h3);
    end
  endtask
  // sixteen bit status read fills lanes 0 and 1
  task automatic t_read16();
    i_ar_size = 3'h1;
    axi_rd(na(8'h10, 3'h1, 1'b0, 1'b1, 8'h00, 8'h00, 3'h0));
    i_ar_size = 3'h0;
    chk("read16 data", rdata, 64'h5D5C);
    chk("read16 last", {rlast, rresp}, {1'b1, naf_pkg::RESP_OKAY});
    chk("cs released", o_cs_n, 2'h3);
  endtask
  task automatic t_prog();
    i_rdy_clr = 1'b1;
    @(posedge i_mclk);
    #1;
    i_rdy_clr = 1'b0;
    axi_wr(na(8'h20, 3'h1, 1'b1, 1'b1, 8'h10, 8'h00, 3'h0), 64'h9999_9999_DDCC_BBAA, 8'h0F);
    push_bytes(2'b00, 64'hDDCC_BBAA, 4);
    exp_q.push_back({2'b10, 8'h10});
    chk_log();
    chk("chip 1 used", cs_seen, 2'h2);
    chk("cs released", o_cs_n, 2'h3);
    chk("ready while busy", o_rdy_flag, 1'b0);
    for (int n = 0; n < 100 && o_rdy_flag !== 1'b1; n++)
      @(posedge i_mclk);
    chk("ready after busy", o_rdy_flag, 1'b1);
  endtask
  task automatic t_unmatched();
    axi_wr(na(8'h30, 3'h1, 1'b0, 1'b1, 8'h00, 8'h00, 3'h0), 64'h55, 8'h01);
    chk_log();
    chk("no chip used", cs_seen, 2'h0);
    chk("unmatched resp", bresp, naf_pkg::RESP_OKAY);
  endtask
  initial
  begin
    repeat (16) @(posedge i_mclk);
    t_reset();
    #1;
    i_arst_n = 1'b1;
    t_cmd(1'b0, 3'h3, 1'b1);
    t_cmd(1'b1, 3'h7, 1'b0);
    t_wkeep();
    t_read();
    t_read16();
    t_cmd(1'b0, 3'h0, 1'b1);
    t_prog();
    t_unmatched();
    close_out();
  end
endmodule
